/* core/t2cr_top.sv */
// Purpose: sixteen-bit timer/counter with capture, auto-reload and up/down count
// Assumes: apb slave, pins synchronous to pclk, one clock domain
// Notes:   each register is one aligned word at four times its index
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "t2cr_map.svh"
module t2cr_top #(
	parameter int ADDR_W   = 12,
	parameter int TICK_DIV = `T2CR_TICK_DIV,
	parameter int BAUD_DIV = `T2CR_BAUD_DIV
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              external_trigger_pin,
	input  wire logic              count_input_pin,
	output logic                   baud_tick,
	output logic                   irq
);
	localparam int TDIV_W = $clog2(TICK_DIV + 1);
	localparam int BDIV_W = $clog2(BAUD_DIV + 1);

	// register state
	t2cr_pkg::t2cr_ctrl_t       ctrl_reg;
	t2cr_pkg::t2cr_ctrl_t       ctrl_next;
	logic                       down_count_enable_reg;
	logic [7:0]                 capture_reload_low_reg;
	logic [7:0]                 capture_reload_high_reg;
	logic [15:0]                count_reg;
	logic [15:0]                count_next;
	logic [15:0]                rcap_next;
	t2cr_pkg::t2cr_bus_state_t  bus_state_reg;
	logic [TDIV_W-1:0]          tick_cnt_reg;
	logic [BDIV_W-1:0]          baud_cnt_reg;
	logic                       baud_tick_reg;

	// bus side
	logic [9:0]  acc_idx;
	logic        acc_aligned;
	logic        acc_mapped;
	logic        wr_fire;
	logic        lane0;
	logic [7:0]  wbyte;
	logic [31:0] rd_value;

	// timer side
	logic [1:0]  fall;
	logic        trig_fall;
	logic        count_fall;
	logic        baud_mode;
	logic        reload_mode;
	logic        down_mode;
	logic        count_up;
	logic        tick_pulse;
	logic        baud_pulse;
	logic        step;
	logic        wrap;
	logic        trig_act;
	logic [15:0] reload_value;
	t2cr_pkg::t2cr_evt_t evt;

	// interrupt side
	logic [`T2CR_EVT_COUNT-1:0] irq_status;
	logic [`T2CR_EVT_COUNT-1:0] irq_enable;
	logic                       irq_clr_we;
	logic                       irq_en_we;

	function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[11:2];
	endfunction : reg_index

	function automatic logic idx_is(input logic [9:0] idx, input logic [9:0] want);
		idx_is = (idx == want);
	endfunction : idx_is

	t2cr_fall_detect #(
		.WIDTH (2)
	) u_fall (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_in     ({count_input_pin, external_trigger_pin}),
		.fall_pulse (fall)
	);

	assign trig_fall  = fall[0];
	assign count_fall = fall[1];

	// address decode
	assign acc_idx     = reg_index(paddr);
	assign acc_aligned = (paddr[1:0] == 2'b00);

	always_comb begin
		if (!acc_aligned) begin
			acc_mapped = 1'b0;
		end else if (idx_is(acc_idx, `T2CR_IDX_CTRL)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_MODE)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_RCAP_LO)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_RCAP_HI)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_CNT_LO)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_CNT_HI)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_IRQ_STAT)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_IRQ_CLR)) begin
			acc_mapped = 1'b1;
		end else if (idx_is(acc_idx, `T2CR_IDX_IRQ_EN)) begin
			acc_mapped = 1'b1;
		end else begin
			acc_mapped = 1'b0;
		end
	end

	// writes land only at the completing edge, byte lane 0 only
	assign wr_fire = psel & penable & pready & pwrite & acc_mapped;
	assign lane0   = pstrb[0];
	assign wbyte   = pwdata[7:0];

	assign irq_clr_we = wr_fire & lane0 & idx_is(acc_idx, `T2CR_IDX_IRQ_CLR);
	assign irq_en_we  = wr_fire & lane0 & idx_is(acc_idx, `T2CR_IDX_IRQ_EN);

	// read mux, snapshot taken in the setup cycle
	always_comb begin
		rd_value = 32'h0000_0000;
		if (!acc_aligned) begin
			rd_value = 32'h0000_0000;
		end else if (idx_is(acc_idx, `T2CR_IDX_CTRL)) begin
			rd_value[7:0] = ctrl_reg;
		end else if (idx_is(acc_idx, `T2CR_IDX_MODE)) begin
			rd_value[`T2CR_MODE_DOWN_COUNT_ENABLE] = down_count_enable_reg;
		end else if (idx_is(acc_idx, `T2CR_IDX_RCAP_LO)) begin
			rd_value[7:0] = capture_reload_low_reg;
		end else if (idx_is(acc_idx, `T2CR_IDX_RCAP_HI)) begin
			rd_value[7:0] = capture_reload_high_reg;
		end else if (idx_is(acc_idx, `T2CR_IDX_CNT_LO)) begin
			rd_value[7:0] = count_reg[7:0];
		end else if (idx_is(acc_idx, `T2CR_IDX_CNT_HI)) begin
			rd_value[7:0] = count_reg[15:8];
		end else if (idx_is(acc_idx, `T2CR_IDX_IRQ_STAT)) begin
			rd_value[`T2CR_EVT_COUNT-1:0] = irq_status;
		end else if (idx_is(acc_idx, `T2CR_IDX_IRQ_EN)) begin
			rd_value[`T2CR_EVT_COUNT-1:0] = irq_enable;
		end else begin
			rd_value = 32'h0000_0000;
		end
	end

	// apb answer: no wait states, ready in the first access cycle, every answer from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state_reg <= t2cr_pkg::T2CR_BUS_IDLE;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			prdata        <= 32'h0000_0000;
		end else begin
			case (bus_state_reg)
				t2cr_pkg::T2CR_BUS_IDLE: begin
					if (psel && !penable) begin
						bus_state_reg <= t2cr_pkg::T2CR_BUS_ANSWER;
						pready        <= 1'b1;
						pslverr       <= ~acc_mapped;
						prdata        <= pwrite ? 32'h0000_0000 : rd_value;
					end
				end
				t2cr_pkg::T2CR_BUS_ANSWER: begin
					bus_state_reg <= t2cr_pkg::T2CR_BUS_IDLE;
					pready        <= 1'b0;
					pslverr       <= 1'b0;
				end
				default: begin
					bus_state_reg <= t2cr_pkg::T2CR_BUS_IDLE;
					pready        <= 1'b0;
					pslverr       <= 1'b0;
				end
			endcase
		end
	end

	// mode decode
	// baud mode forces reload, select bit ignored
	assign baud_mode   = ctrl_reg.rx_baud_sel | ctrl_reg.tx_baud_sel;
	assign reload_mode = ~ctrl_reg.capture_reload_select | baud_mode;
	assign down_mode   = down_count_enable_reg & reload_mode & ~baud_mode;
	assign count_up    = ~down_mode | external_trigger_pin;

	// prescale: ticks are one-cycle enables, never a second clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
		end else if (tick_cnt_reg == TDIV_W'(TICK_DIV - 1)) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TDIV_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt_reg <= '0;
		end else if (baud_cnt_reg == BDIV_W'(BAUD_DIV - 1)) begin
			baud_cnt_reg <= '0;
		end else begin
			baud_cnt_reg <= baud_cnt_reg + BDIV_W'(1);
		end
	end

	assign tick_pulse = (tick_cnt_reg == TDIV_W'(TICK_DIV - 1));
	assign baud_pulse = (baud_cnt_reg == BDIV_W'(BAUD_DIV - 1));

	// no steps while run control is clear
	always_comb begin
		if (!ctrl_reg.run_control) begin
			step = 1'b0;
		end else if (baud_mode) begin
			step = baud_pulse;
		end else if (ctrl_reg.counter_select) begin
			step = count_fall;
		end else begin
			step = tick_pulse;
		end
	end

	assign reload_value = {capture_reload_high_reg, capture_reload_low_reg};

	// down count wraps where count meets the reload value
	assign wrap = count_up ? (count_reg == `T2CR_COUNT_TOP) : (count_reg == reload_value);

	// trigger edge acts only when enabled and not in baud mode
	assign trig_act = trig_fall & ctrl_reg.external_trigger_enable & ~baud_mode;

	// count path; software byte writes win over the step
	always_comb begin
		count_next = count_reg;
		if (step) begin
			if (count_up) begin
				if (wrap && reload_mode) begin
					count_next = reload_value;
				end else begin
					count_next = count_reg + 16'h0001;
				end
			end else begin
				count_next = wrap ? `T2CR_COUNT_TOP : count_reg - 16'h0001;
			end
		end
		if (trig_act && reload_mode) begin
			count_next = reload_value;
		end
		if (wr_fire && lane0 && idx_is(acc_idx, `T2CR_IDX_CNT_LO)) begin
			count_next[7:0] = wbyte;
		end
		if (wr_fire && lane0 && idx_is(acc_idx, `T2CR_IDX_CNT_HI)) begin
			count_next[15:8] = wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= `T2CR_RST_COUNT;
		end else begin
			count_reg <= count_next;
		end
	end

	// capture/reload registers; a capture wins over a software write
	always_comb begin
		rcap_next = reload_value;
		if (wr_fire && lane0 && idx_is(acc_idx, `T2CR_IDX_RCAP_LO)) begin
			rcap_next[7:0] = wbyte;
		end
		if (wr_fire && lane0 && idx_is(acc_idx, `T2CR_IDX_RCAP_HI)) begin
			rcap_next[15:8] = wbyte;
		end
		if (trig_act && !reload_mode) begin
			rcap_next[7:0]  = count_reg[7:0];
			rcap_next[15:8] = count_reg[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_reload_low_reg  <= `T2CR_RST_BYTE;
			capture_reload_high_reg <= `T2CR_RST_BYTE;
		end else begin
			capture_reload_low_reg  <= rcap_next[7:0];
			capture_reload_high_reg <= rcap_next[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			down_count_enable_reg <= 1'b0;
		end else if (wr_fire && lane0 && idx_is(acc_idx, `T2CR_IDX_MODE)) begin
			down_count_enable_reg <= wbyte[`T2CR_MODE_DOWN_COUNT_ENABLE];
		end
	end

	// events
	assign evt.overflow = step & wrap & ~baud_mode;
	assign evt.ext_edge = trig_act;
	assign evt.capture  = trig_act & ~reload_mode;

	// control register; hardware sets beat a same-cycle software clear
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_fire && lane0 && idx_is(acc_idx, `T2CR_IDX_CTRL)) begin
			ctrl_next = wbyte;
		end
		// overflow sets flag, only software clears
		if (evt.overflow) begin
			ctrl_next.overflow_flag = 1'b1;
		end
		if (evt.ext_edge) begin
			ctrl_next.external_flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `T2CR_RST_BYTE;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// overflow in baud mode feeds the serial port, not the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_tick_reg <= 1'b0;
		end else begin
			baud_tick_reg <= step & wrap & baud_mode;
		end
	end

	assign baud_tick = baud_tick_reg;

	t2cr_irq #(
		.WIDTH (`T2CR_EVT_COUNT)
	) u_irq (
		.pclk       (pclk),
		.presetn    (presetn),
		.event_set  ({evt.capture, evt.ext_edge, evt.overflow}),
		.clear_we   (irq_clr_we),
		.enable_we  (irq_en_we),
		.wdata      (wbyte[`T2CR_EVT_COUNT-1:0]),
		.status_reg (irq_status),
		.enable_reg (irq_enable),
		.irq_reg    (irq)
	);

endmodule : t2cr_top

/* core/t2cr_map.svh */
// Purpose: offsets, field positions, reset values and counts of the timer block
// Assumes: register indices; the byte address on the bus is four times the index
// Notes:   definitions only
`ifndef T2CR_MAP_SVH
`define T2CR_MAP_SVH

// register indices
`define T2CR_IDX_CTRL      10'h0c8
`define T2CR_IDX_MODE      10'h0c9
`define T2CR_IDX_RCAP_LO   10'h0ca
`define T2CR_IDX_RCAP_HI   10'h0cb
`define T2CR_IDX_CNT_LO    10'h0cc
`define T2CR_IDX_CNT_HI    10'h0cd
`define T2CR_IDX_IRQ_STAT  10'h0e0
`define T2CR_IDX_IRQ_CLR   10'h0e1
`define T2CR_IDX_IRQ_EN    10'h0e2

// control register fields
`define T2CR_CTRL_OVF      7
`define T2CR_CTRL_EXTF     6
`define T2CR_CTRL_RXBAUD   5
`define T2CR_CTRL_TXBAUD   4
`define T2CR_CTRL_EXEN     3
`define T2CR_CTRL_RUN      2
`define T2CR_CTRL_CNTSEL   1
`define T2CR_CTRL_CPRL     0

// mode register fields
`define T2CR_MODE_DOWN_COUNT_ENABLE     0

// interrupt status bits
`define T2CR_EVT_OVF       0
`define T2CR_EVT_EXT       1
`define T2CR_EVT_CAP       2
`define T2CR_EVT_COUNT     3

// reset values and count top
`define T2CR_RST_BYTE      8'h00
`define T2CR_RST_COUNT     16'h0000
`define T2CR_COUNT_TOP     16'hffff

// clocks per timer tick and per baud-mode tick
`define T2CR_TICK_DIV      12
`define T2CR_BAUD_DIV      2

`endif

/* core/t2cr_pkg.sv */
// Purpose: types shared by the timer block
// Assumes: constants live in t2cr_map.svh
// Notes:   control layout matches bit 7 down to bit 0
package t2cr_pkg;

	typedef struct packed {
		logic overflow_flag;
		logic external_flag;
		logic rx_baud_sel;
		logic tx_baud_sel;
		logic external_trigger_enable;
		logic run_control;
		logic counter_select;
		logic capture_reload_select;
	} t2cr_ctrl_t;

	typedef struct packed {
		logic capture;
		logic ext_edge;
		logic overflow;
	} t2cr_evt_t;

	typedef enum logic [1:0] {
		T2CR_BUS_IDLE   = 2'b01,
		T2CR_BUS_ANSWER = 2'b10
	} t2cr_bus_state_t;

endpackage : t2cr_pkg

/* core/t2cr_fall_detect.sv */
// Purpose: falling-edge detect on synchronous input pins
// Assumes: inputs already synchronous to pclk
// Notes:   pulse is combinational from one history flop
`timescale 1ns/1ps
module t2cr_fall_detect #(
	parameter int WIDTH = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] fall_pulse
);
	logic [WIDTH-1:0] prev_reg;

	// history starts high so a low pin at reset counts as an edge in the first cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= '1;
		end else begin
			prev_reg <= pin_in;
		end
	end

	assign fall_pulse = prev_reg & ~pin_in;

endmodule : t2cr_fall_detect

/* core/t2cr_irq.sv */
// Purpose: sticky event status, enable mask and one level interrupt
// Assumes: clear is write-one-to-clear, one cycle strobes
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module t2cr_irq #(
	parameter int WIDTH = 3
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] event_set,
	input  wire logic             clear_we,
	input  wire logic             enable_we,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] status_reg,
	output logic      [WIDTH-1:0] enable_reg,
	output logic                  irq_reg
);
	logic [WIDTH-1:0] status_next;
	logic [WIDTH-1:0] enable_next;

	always_comb begin
		status_next = status_reg;
		enable_next = enable_reg;
		if (clear_we) begin
			status_next = status_next & ~wdata;
		end
		status_next = status_next | event_set;
		if (enable_we) begin
			enable_next = wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
			enable_reg <= '0;
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			enable_reg <= enable_next;
			// from next values so irq tracks status with no extra lag
			irq_reg    <= |(status_next & enable_next);
		end
	end

endmodule : t2cr_irq

/* tb/t2cr_properties.sv */
// Purpose: bus and interrupt properties of the timer block
// Assumes: one clock, async active-low reset
// Notes:   watches top-level ports only
`timescale 1ns/1ps
`include "t2cr_map.svh"
module t2cr_properties #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              baud_tick,
	input wire logic              irq
);
	localparam logic [11:0] A_MD = {`T2CR_IDX_MODE, 2'b00};
	localparam logic [11:0] A_CR = {`T2CR_IDX_IRQ_CLR, 2'b00};
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_read(a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	a_ready_answer: assert property (s_setup |=> pready)
		else $error("no answer one cycle after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held over two cycles");
	a_ready_quiet: assert property (!psel |=> !pready)
		else $error("ready without select");
	a_err_misalign: assert property (s_setup ##0 (paddr[1:0] != 2'b00) |=> pready && pslverr)
		else $error("misaligned access not refused");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error outside access phase");
	a_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bytes not zero");
	a_mode_unused: assert property (s_read(A_MD) |=> prdata[31:1] == 31'h0)
		else $error("unused mode bits read nonzero");
	a_clear_reads_zero: assert property (s_read(A_CR) |=> prdata == 32'h0)
		else $error("clear register reads nonzero");
	a_irq_sw_clear: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("interrupt dropped without a write");
	a_tick_pulse: assert property (baud_tick |=> !baud_tick)
		else $error("baud tick longer than one cycle");
endmodule : t2cr_properties

bind t2cr_top t2cr_properties #(.ADDR_W(ADDR_W)) i_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .baud_tick(baud_tick), .irq(irq)
);

/* tb/t2cr_pin_model.sv */
// Purpose: far-side model of trigger and count input pins
// Assumes: pins idle high, as pulled-up port lines
// Notes:   changes only just after a rising edge
`timescale 1ns/1ps
module t2cr_pin_model (
	input  wire logic pclk,
	output logic      external_trigger_pin,
	output logic      count_input_pin
);
	initial begin
		external_trigger_pin = 1'b1;
		count_input_pin      = 1'b1;
	end
	task automatic trig_fall(input int low_cycles);
		@(posedge pclk);
		external_trigger_pin <= 1'b0;
		repeat (low_cycles) @(posedge pclk);
		external_trigger_pin <= 1'b1;
	endtask : trig_fall
	task automatic set_trig(input logic lvl);
		@(posedge pclk);
		external_trigger_pin <= lvl;
	endtask : set_trig
	task automatic count_pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			count_input_pin <= 1'b0;
			repeat (2) @(posedge pclk);
			count_input_pin <= 1'b1;
		end
	endtask : count_pulses
endmodule : t2cr_pin_model

/* tb/testbench.sv */
// Purpose: self-checking bench for the timer block
// Assumes: apb master here, pins from the pin model
// Notes:   tick divider of 2 keeps the run short
`timescale 1ns/1ps
`include "t2cr_map.svh"
module testbench;
	localparam logic [11:0] A_CT = {`T2CR_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_MD = {`T2CR_IDX_MODE, 2'b00};
	localparam logic [11:0] A_RL = {`T2CR_IDX_RCAP_LO, 2'b00};
	localparam logic [11:0] A_RH = {`T2CR_IDX_RCAP_HI, 2'b00};
	localparam logic [11:0] A_CL = {`T2CR_IDX_CNT_LO, 2'b00};
	localparam logic [11:0] A_CH = {`T2CR_IDX_CNT_HI, 2'b00};
	localparam logic [11:0] A_ST = {`T2CR_IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] A_CR = {`T2CR_IDX_IRQ_CLR, 2'b00};
	localparam logic [11:0] A_EN = {`T2CR_IDX_IRQ_EN, 2'b00};
	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, trig, cnt_pin, baud_tick, irq, e, lane_off;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [15:0] v;
	logic [7:0]  q;
	int          n_fail, compares, seed, n;
	logic [11:0] rst_regs [8] = '{A_CT, A_MD, A_RL, A_RH, A_CL, A_CH, A_ST, A_EN};
	logic [1:0]  dir_in [3] = '{2'b11, 2'b10, 2'b00};
	logic [7:0]  dir_hi [3] = '{8'h80, 8'h7f, 8'h80};

	t2cr_top #(.TICK_DIV(2)) i_t2cr_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_trigger_pin(trig), .count_input_pin(cnt_pin),
		.baud_tick(baud_tick), .irq(irq)
	);
	t2cr_pin_model i_t2cr_pin_model (
		.pclk(pclk), .external_trigger_pin(trig), .count_input_pin(cnt_pin)
	);
	always #25 pclk = ~pclk;

	task automatic give_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// request held until ready is seen high at a rising edge; data taken there
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
			output logic [7:0] rq, output logic re);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($random(seed)), d};
		pstrb <= {3'($random(seed)), ~lane_off};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			give_verdict();
		end
		rq = prdata[7:0];
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] rq;
		logic       re;
		apb(1'b1, a, d, rq, re);
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [7:0] exp, input string what);
		logic [7:0] rq;
		logic       re;
		apb(1'b0, a, 8'h00, rq, re);
		chk(what, exp, rq);
	endtask : rc
	task automatic wait_sig(input logic pick);
		int k;
		k = 0;
		while ((pick ? baud_tick : irq) !== 1'b1 && k < 200) begin
			@(negedge pclk);
			k++;
		end
		if (k >= 200) begin
			n_fail++;
			give_verdict();
		end
	endtask : wait_sig

	initial begin
		{pclk, presetn, psel, penable, pwrite, lane_off, n_fail, compares} = '0;
		{paddr, pwdata} = '0;
		pstrb = 4'hf;
		seed = 73235;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_regs[i]) rc(rst_regs[i], 8'h00, "reset value");
		for (int i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			wr(A_RL + 12'(4 * i), v[7:0]);
			repeat (10) @(posedge pclk);
			rc(A_RL + 12'(4 * i), v[7:0], "readback");
		end
		wr(A_MD, 8'hff);
		rc(A_MD, 8'h01, "mode");
		rc(A_CR, 8'h00, "clear reads");
		apb(1'b0, 12'h3fc, 8'h00, q, e);
		chk("unmapped err", 8'h01, {7'h0, e});
		apb(1'b1, 12'h322, 8'h5a, q, e);
		chk("misaligned err", 8'h01, {7'h0, e});
		// capture on edge, masked then enabled
		wr(A_MD, 8'h00);
		v = 16'($random(seed));
		wr(A_CL, v[7:0]);
		wr(A_CH, v[15:8]);
		wr(A_CT, 8'h09);
		i_t2cr_pin_model.trig_fall(2);
		rc(A_RL, v[7:0], "capture lo");
		rc(A_RH, v[15:8], "capture hi");
		rc(A_CT, 8'h49, "ctrl ext flag");
		rc(A_ST, 8'h06, "status");
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(A_EN, 8'h04);
		repeat (2) @(negedge pclk);
		chk("irq enabled", 8'h01, {7'h0, irq});
		wr(A_CR, 8'h07);
		repeat (2) @(negedge pclk);
		chk("irq cleared", 8'h00, {7'h0, irq});
		wr(A_CT, 8'h01);
		wr(A_CL, ~v[7:0]);
		i_t2cr_pin_model.trig_fall(2);
		rc(A_RL, v[7:0], "no capture");
		// lane 0 strobe low: byte write refused
		lane_off = 1'b1;
		wr(A_CL, v[7:0]);
		lane_off = 1'b0;
		rc(A_CL, ~v[7:0], "lane 0 off");
		v = 16'($random(seed));
		wr(A_RL, v[7:0]);
		wr(A_RH, v[15:8]);
		wr(A_CT, 8'h08);
		i_t2cr_pin_model.trig_fall(1);
		rc(A_CL, v[7:0], "reload lo");
		rc(A_CH, v[15:8], "reload hi");
		wr(A_RL, 8'h00);
		wr(A_RH, 8'h12);
		wr(A_CL, 8'hff);
		wr(A_CH, 8'hff);
		wr(A_CR, 8'h07);
		wr(A_EN, 8'h01);
		wr(A_CT, 8'h04);
		wait_sig(1'b0);
		wr(A_CT, 8'h80);
		rc(A_CH, 8'h12, "overflow reload");
		rc(A_CT, 8'h80, "flag sticky");
		rc(A_ST, 8'h01, "ovf status");
		wr(A_CR, 8'h01);
		wr(A_CT, 8'h00);
		rc(A_CT, 8'h00, "flag cleared");
		foreach (dir_in[i]) begin
			wr(A_MD, {7'h0, dir_in[i][1]});
			i_t2cr_pin_model.set_trig(dir_in[i][0]);
			wr(A_CL, 8'h00);
			wr(A_CH, 8'h80);
			wr(A_CT, 8'h04);
			repeat (40) @(posedge pclk);
			wr(A_CT, 8'h00);
			rc(A_CH, dir_hi[i], "direction");
		end
		i_t2cr_pin_model.set_trig(1'b1);
		n = 1 + ($random(seed) & 7);
		wr(A_CL, 8'h00);
		wr(A_CH, 8'h00);
		wr(A_CT, 8'h06);
		i_t2cr_pin_model.count_pulses(n);
		wr(A_CT, 8'h00);
		rc(A_CL, 8'(n), "pin count");
		// baud mode ignores edge, no flag
		wr(A_RL, 8'hff);
		wr(A_RH, 8'hff);
		wr(A_CL, 8'hff);
		wr(A_CH, 8'hff);
		q = ($random(seed) & 1) ? 8'h10 : 8'h20;
		wr(A_CT, q | 8'h0c);
		i_t2cr_pin_model.trig_fall(2);
		wait_sig(1'b1);
		wr(A_CT, q | 8'h08);
		rc(A_CT, q | 8'h08, "baud flags");
		// second reset in mid-run, after activity
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_regs[i]) rc(rst_regs[i], 8'h00, "reset again");
		give_verdict();
	end
endmodule : testbench
